// ==== gpio_port.sv ====
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "gpio_port_defs.svh"

module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] pin_in,
  output pad_out_s pads,
  input wire logic xtal_osc_mode,
  input wire logic master_clear_mode,
  output logic pin0_sink_en,
  output logic wake,
  output logic irq,
  output logic [15:0] irq_vector
);

  // register state
  pin_vec_t out_latch_q;
  pin_vec_t dir_q;
  logic [7:0] analog_q;
  pin_vec_t wpu_q;
  pin_vec_t ioc_q;
  pin_vec_t last_read_q;
  control_s ctl_q;
  control_s ctl_d;

  // bus answer registers
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // pin side registers
  pad_out_s pads_q;
  pad_out_s pads_d;
  logic sink_q;
  logic wake_q;
  logic irq_q;
  logic [15:0] vec_q;

  // pins 0,1,2,4 carry analog channels 0..3; pins 3 and 5 have none
  function automatic pin_vec_t pin_analog(input logic [7:0] ans);
    pin_analog = {1'b0, ans[3], 1'b0, ans[2:0]};
  endfunction : pin_analog

  function automatic logic addr_is(
    input logic [ADDR_W-1:0] a,
    input logic [7:0] ofs
  );
    addr_is = (a == ADDR_W'(ofs));
  endfunction : addr_is

  // address decode
  wire sel_data = addr_is(paddr, `OFS_PIN_DATA);
  wire sel_dir = addr_is(paddr, `OFS_PIN_DIRECTION);
  wire sel_an = addr_is(paddr, `OFS_ANALOG_SELECT);
  wire sel_wpu = addr_is(paddr, `OFS_PULLUP_ENABLE);
  wire sel_ioc = addr_is(paddr, `OFS_CHANGE_IRQ_ENABLE);
  wire sel_ctl = addr_is(paddr, `OFS_CONTROL);
  wire sel_any = sel_data | sel_dir | sel_an | sel_wpu | sel_ioc | sel_ctl;

  // setup phase and access completion
  wire setup = psel & ~penable;
  wire done = psel & penable & pready_q;
  wire wr_lo = done & pwrite & pstrb[0] & sel_any;
  wire rd_data_done = done & ~pwrite & sel_data;

  // forced and effective configuration
  wire [5:0] xtal_force = xtal_osc_mode ? `XTAL_MASK : 6'h00;
  wire [5:0] an_pin = pin_analog(analog_q);
  wire [5:0] pin3_bit = 6'h08;
  // pin 3 is input only
  wire [5:0] dir_eff = dir_q | pin3_bit | xtal_force;
  wire [5:0] wpu_eff = (wpu_q & `PULLUP_IMPL_MASK) | xtal_force;
  wire [5:0] ioc_eff = ioc_q | xtal_force;

  // digital input path: analog pins and master clear read zero
  wire [5:0] master_clear_pin_mask = master_clear_mode ? pin3_bit : 6'h00;
  wire [5:0] pin_rd = pin_in & ~an_pin & ~master_clear_pin_mask;

  // change detection against the last-read latch
  wire [5:0] live_ioc = ioc_eff & ~an_pin;
  wire [5:0] mismatch_vec = live_ioc & (pin_rd ^ last_read_q);
  wire mismatch = |mismatch_vec;
  // a change landing on a port access is dropped, like the original
  wire port_busy = psel & sel_data;
  wire flag_set = mismatch & ~port_busy;
  wire flag_wr = wr_lo & sel_ctl;
  wire flag_clr = flag_wr & ~pwdata[`CTL_FLAG_BIT];

  // read mux
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (sel_data) begin
      rd_val = {2'b00, pin_rd};
    end else if (sel_dir) begin
      rd_val = {2'b00, dir_eff};
    end else if (sel_an) begin
      rd_val = analog_q;
    end else if (sel_wpu) begin
      rd_val = {2'b00, wpu_eff};
    end else if (sel_ioc) begin
      rd_val = {2'b00, ioc_eff};
    end else if (sel_ctl) begin
      rd_val = {4'h0, ctl_q};
    end
  end

  // control next value: hardware set wins over software clear
  always_comb begin
    ctl_d = ctl_q;
    if (flag_wr) begin
      ctl_d.global_irq_enable = pwdata[`CTL_GIE_BIT];
      ctl_d.pullup_off = pwdata[`CTL_PULLUP_OFF_BIT];
      ctl_d.low_power_wake = pwdata[`CTL_LOW_POWER_WAKE_BIT];
    end
    ctl_d.flag = flag_set | (ctl_q.flag & ~flag_clr);
  end

  // pad drive: analog select does not stop the output driver
  always_comb begin
    pads_d.level = out_latch_q;
    pads_d.oe = ~dir_eff;
    // pull-up needs own bit, global permit, input mode, digital mode
    pads_d.pull = wpu_eff & dir_eff & ~an_pin
                & {6{~ctl_q.pullup_off}};
    pads_d.pull[`PIN3] = master_clear_mode;
  end

  // APB answer: one wait-free access phase, zero-wait after setup
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~sel_any;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
      end
    end
  end

  // registers loaded with their reset values by rst_b
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_latch_q <= `RST_PIN_DATA;
      dir_q <= `RST_PIN_DIRECTION;
      analog_q <= `RST_ANALOG_SELECT;
      wpu_q <= `RST_PULLUP_ENABLE;
    end else if (wr_lo) begin
      // full-byte write stores into the latch, never the pins
      if (sel_data) begin
        out_latch_q <= pwdata[5:0];
      end
      if (sel_dir) begin
        dir_q <= pwdata[5:0];
      end
      if (sel_an) begin
        analog_q <= pwdata[7:0];
      end
      if (sel_wpu) begin
        wpu_q <= pwdata[5:0];
      end
    end
  end

  // change enables clear on power-on only, not on a plain reset
  always_ff @(posedge clk or negedge por_b) begin
    if (!por_b) begin
      ioc_q <= `RST_CHANGE_IRQ_ENABLE;
    end else if (wr_lo & sel_ioc) begin
      ioc_q <= pwdata[5:0];
    end
  end

  // control register: pull-ups start off, flag and enables clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= `RST_CONTROL;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // last-read latch only clears on power-on, so a mismatch survives
  // other resets and sets the flag again afterwards
  always_ff @(posedge clk or negedge por_b) begin
    if (!por_b) begin
      last_read_q <= `RST_LAST_READ;
    end else if (rd_data_done) begin
      last_read_q <= prdata_q[5:0];
    end else if (done & pwrite & sel_data) begin
      last_read_q <= pin_rd;
    end
  end

  // pin side and core signals
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pads_q <= '0;
      sink_q <= 1'b0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
      vec_q <= 16'h0000;
    end else begin
      pads_q <= pads_d;
      sink_q <= ctl_q.low_power_wake;
      wake_q <= ctl_q.flag;
      irq_q <= ctl_q.flag & ctl_q.global_irq_enable;
      vec_q <= (ctl_q.flag & ctl_q.global_irq_enable) ? `IRQ_VECTOR : 16'h0000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pads = pads_q;
  assign pin0_sink_en = sink_q;
  assign wake = wake_q;
  assign irq = irq_q;
  assign irq_vector = vec_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b || !por_b);

  // pin 3 is never driven
  AST_PIN3_NO_DRIVE: assert property (
    ##1 !pads_q.oe[`PIN3]
  ) else $error("pin 3 driven");

  // direction read always shows pin 3 as input
  AST_DIR_READ_PIN3: assert property (
    done && !pwrite && sel_dir |-> prdata_q[`PIN3]
  ) else $error("pin 3 direction read zero");

  // crystal mode forces bits 5:4 on direction, pull-up and change-enable reads
  AST_XTAL_FORCE: assert property (
    setup && !pwrite && xtal_osc_mode && (sel_dir || sel_wpu || sel_ioc)
    |=> prdata_q[5:4] == 2'b11
  ) else $error("crystal mode bits not forced");

  // unimplemented bits read zero
  AST_UPPER_ZERO: assert property (
    setup && !pwrite && !sel_an
    |=> prdata_q[31:6] == 26'h0 && !(sel_wpu && prdata_q[`PIN3])
  ) else $error("unimplemented bits read one");

  // analog pins read zero
  AST_ANALOG_READS_ZERO: assert property (
    setup && !pwrite && sel_data |=> (prdata_q[5:0] & $past(an_pin)) == 0
  ) else $error("analog pin read nonzero");

  // no pull-up on an output pin
  AST_PULL_OFF_OUTPUT: assert property (
    ##1 (pads_q.pull & ~pin3_bit & ~$past(dir_eff)) == 6'h00
  ) else $error("pull-up on output pin");

  // global control gates every pull-up except pin 3
  AST_GLOBAL_PULL: assert property (
    ctl_q.pullup_off |=> (pads_q.pull & ~pin3_bit) == 6'h00
  ) else $error("pull-up while globally off");

  // persisting mismatch keeps the flag set
  AST_FLAG_SET: assert property (
    flag_set |=> ctl_q.flag
  ) else $error("mismatch did not set flag");

  // flag holds until a write of zero
  AST_FLAG_HOLD: assert property (
    ctl_q.flag && !flag_clr |=> ctl_q.flag
  ) else $error("flag dropped without clear");

  // interrupt and vector follow flag and global enable
  AST_IRQ_GATE: assert property (
    ctl_q.flag && ctl_q.global_irq_enable |=> irq_q && vec_q == `IRQ_VECTOR
  ) else $error("interrupt not raised");

  AST_IRQ_NEEDS_GIE: assert property (
    !ctl_q.global_irq_enable |=> !irq_q
  ) else $error("interrupt without global enable");

  // sink follows the enable within one cycle
  AST_SINK: assert property (
    $rose(ctl_q.low_power_wake) |=> sink_q
  ) else $error("sink not enabled");

  // wake follows flag
  AST_WAKE: assert property (
    ctl_q.flag |=> wake_q
  ) else $error("no wake on flag");

  // every setup is answered at the next edge
  AST_READY: assert property (
    setup |=> pready_q ##1 !pready_q
  ) else $error("bus answer late");

  // a clear with no mismatch drops the flag
  AST_FLAG_CLEAR: assert property (
    flag_clr && !flag_set |=> !ctl_q.flag
  ) else $error("flag not cleared");

  // the flag never rises without an enabled mismatch
  AST_FLAG_NEEDS_MISMATCH: assert property (
    !ctl_q.flag && !mismatch |=> !ctl_q.flag
  ) else $error("flag set without mismatch");

  // a completed port read loads the last-read latch
  AST_LAST_READ: assert property (
    rd_data_done |=> last_read_q == $past(prdata_q[5:0])
  ) else $error("last-read latch not loaded");

  // a port write fills the output latch and ends the mismatch
  AST_PORT_WRITE: assert property (
    wr_lo && sel_data
    |=> out_latch_q == $past(pwdata[5:0]) && last_read_q == $past(pin_rd)
  ) else $error("port write lost");

  // analog pins never get a weak pull-up
  AST_PULL_ANALOG_OFF: assert property (
    ##1 (pads_q.pull & ~pin3_bit & $past(an_pin)) == 6'h00
  ) else $error("pull-up on analog pin");

  // pin 3 pull-up follows master clear mode only
  AST_PIN3_PULL: assert property (
    ##1 pads_q.pull[`PIN3] == $past(master_clear_mode)
  ) else $error("pin 3 pull-up wrong");

  // analog select leaves the driver on the latch value
  AST_OUTPUT_DRIVE: assert property (
    ##1 pads_q.level == $past(out_latch_q) && pads_q.oe == ~$past(dir_eff)
  ) else $error("pad drive wrong");

  // no vector while the interrupt is low
  AST_VECTOR_IDLE: assert property (
    !irq_q |-> vec_q == 16'h0000
  ) else $error("vector without interrupt");

endmodule : gpio_port

// ==== gpio_port_defs.svh ====
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

// register byte offsets
`define OFS_PIN_DATA 8'h00
`define OFS_PIN_DIRECTION 8'h04
`define OFS_ANALOG_SELECT 8'h08
`define OFS_PULLUP_ENABLE 8'h0C
`define OFS_CHANGE_IRQ_ENABLE 8'h10
`define OFS_CONTROL 8'h14

// control register fields
`define CTL_FLAG_BIT 0
`define CTL_GIE_BIT 1
`define CTL_PULLUP_OFF_BIT 2
`define CTL_LOW_POWER_WAKE_BIT 3

// reset values
`define RST_PIN_DATA 6'h00
`define RST_PIN_DIRECTION 6'h3F
`define RST_ANALOG_SELECT 8'hFF
`define RST_PULLUP_ENABLE 6'h37
`define RST_CHANGE_IRQ_ENABLE 6'h00
`define RST_LAST_READ 6'h00
`define RST_CONTROL 4'h4

// fixed pin positions and masks
`define PIN3 3
`define XTAL_MASK 6'h30
`define PULLUP_IMPL_MASK 6'h37

// vector taken by the core on a recognised change interrupt
`define IRQ_VECTOR 16'h0004

`endif

// ==== gpio_port_pkg.sv ====
package gpio_port_pkg;

  typedef logic [5:0] pin_vec_t;

  typedef struct packed {
    pin_vec_t level;
    pin_vec_t oe;
    pin_vec_t pull;
  } pad_out_s;

  typedef struct packed {
    logic low_power_wake;
    logic pullup_off;
    logic global_irq_enable;
    logic flag;
  } control_s;

endpackage : gpio_port_pkg

// ==== pin_board.sv ====
`timescale 1ns/1ps

module pin_board
  import gpio_port_pkg::*;
(
  input wire logic clk,
  input wire pad_out_s pads,
  input wire logic sink_en,
  input wire logic [5:0] ext_val,
  input wire logic [5:0] ext_en,
  output logic [5:0] pin_in
);
  logic [3:0] cap_q = 4'h0;
  logic [5:0] float_q = 6'h15;
  logic [5:0] wire_lvl;
  // released lines wander so a stale level is never mistaken for a drive
  always @(posedge clk) float_q <= ~float_q;
  // capacitor on pin 0: charged by a high drive, drained only by the sink
  always @(posedge clk) begin
    if (pads.oe[0] && pads.level[0]) cap_q <= 4'hf;
    else if (sink_en && cap_q != 4'h0) cap_q <= cap_q - 4'h1;
  end
  always_comb begin
    for (int b = 0; b < 6; b++) begin
      if (pads.oe[b]) wire_lvl[b] = pads.level[b];
      else if (ext_en[b]) wire_lvl[b] = ext_val[b];
      else if (pads.pull[b]) wire_lvl[b] = 1'b1;
      else wire_lvl[b] = float_q[b];
    end
    if (!pads.oe[0] && !ext_en[0]) wire_lvl[0] = (cap_q != 4'h0);
  end
  assign pin_in = wire_lvl;
endmodule : pin_board

// ==== six_bit_port_with_change_wake_bench.sv ====
`timescale 1ns/1ps
`include "gpio_port_defs.svh"

module six_bit_port_with_change_wake_bench;
  import gpio_port_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, pin0_sink_en, wake, irq, rerr;
  logic [15:0] irq_vector;
  logic [5:0] pin_in, am;
  pad_out_s pads;
  logic xtal = 1'b0, master_clear_pin = 1'b0;
  logic [5:0] ext_val = 6'h00, ext_en = 6'h3f;
  logic [31:0] lfsr_q = 32'h4532_c7d1;
  int miscompares = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  gpio_port u_gpio_port (.clk(clk), .rst_b(rst_b), .por_b(por_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pads(pads),
    .xtal_osc_mode(xtal), .master_clear_mode(master_clear_pin),
    .pin0_sink_en(pin0_sink_en), .wake(wake), .irq(irq),
    .irq_vector(irq_vector));

  pin_board u_pin_board (.clk(clk), .pads(pads), .sink_en(pin0_sink_en),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // driven pins read back their latch, pin 3 the board, analog pins zero
  function logic [7:0] pin_exp(input logic [5:0] d, input logic [5:0] e,
                               input logic [5:0] a);
    return {2'b00, ((d & 6'h37) | (e & 6'h08)) & ~a};
  endfunction : pin_exp

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task chk6(input logic [5:0] got, input logic [5:0] exp);
    chk({26'h0, got}, {26'h0, exp});
  endtask : chk6

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'hf);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rdat, {24'h0, e});
  endtask : rd

  task end_sim;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  initial begin
    #100000;
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    rd(`OFS_PIN_DIRECTION, 8'h3f);
    rd(`OFS_ANALOG_SELECT, 8'hff);
    rd(`OFS_PULLUP_ENABLE, 8'h37);
    rd(`OFS_CHANGE_IRQ_ENABLE, 8'h00);
    rd(`OFS_CONTROL, 8'h04);
    chk6(pads.pull, 6'h00);
    apb(1'b0, 8'h18, 32'h0000_0000, 4'h0);
    chk({31'h0, rerr}, 32'h0000_0001);
    wr(`OFS_PULLUP_ENABLE, 8'hff);
    rd(`OFS_PULLUP_ENABLE, 8'h37);
    wr(`OFS_CHANGE_IRQ_ENABLE, 8'hff);
    rd(`OFS_CHANGE_IRQ_ENABLE, 8'h3f);
    // a write with byte lane 0 off must leave the register alone
    apb(1'b1, `OFS_CHANGE_IRQ_ENABLE, 32'h0000_0000, 4'h0);
    rd(`OFS_CHANGE_IRQ_ENABLE, 8'h3f);
    wr(`OFS_CHANGE_IRQ_ENABLE, 8'h00);
    wr(`OFS_PIN_DIRECTION, 8'h00);
    rd(`OFS_PIN_DIRECTION, 8'h08);
    $display("test reset_and_masks done");
    // random latch, board and analog patterns; outputs keep driving
    for (int i = 0; i < 6; i++) begin
      lfsr_q = lfsr(lfsr_q);
      ext_val <= lfsr_q[13:8];
      am = {1'b0, lfsr_q[19], 1'b0, lfsr_q[18:16]};
      wr(`OFS_ANALOG_SELECT, {lfsr_q[23:20], lfsr_q[19:16]});
      rd(`OFS_ANALOG_SELECT, lfsr_q[23:16]);
      wr(`OFS_PIN_DATA, {2'b00, lfsr_q[5:0]});
      repeat (3) @(posedge clk);
      chk6(pads.oe, 6'h37);
      chk6(pads.level & pads.oe, lfsr_q[5:0] & 6'h37);
      rd(`OFS_PIN_DATA, pin_exp(lfsr_q[5:0], lfsr_q[13:8], am));
    end
    $display("test drive_and_read done");
    xtal <= 1'b1;
    rd(`OFS_PIN_DIRECTION, 8'h38);
    rd(`OFS_PULLUP_ENABLE, 8'h37);
    rd(`OFS_CHANGE_IRQ_ENABLE, 8'h30);
    chk6(pads.oe, 6'h07);
    xtal <= 1'b0;
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_ANALOG_SELECT, 8'h00);
    wr(`OFS_PIN_DIRECTION, 8'h3f);
    repeat (3) @(posedge clk);
    chk6(pads.pull, 6'h37);
    wr(`OFS_PIN_DIRECTION, 8'h3e);
    repeat (3) @(posedge clk);
    chk6(pads.pull, 6'h36);
    wr(`OFS_ANALOG_SELECT, 8'h02);
    repeat (3) @(posedge clk);
    chk6(pads.pull, 6'h34);
    master_clear_pin <= 1'b1;
    repeat (3) @(posedge clk);
    chk6(pads.pull, 6'h3c);
    master_clear_pin <= 1'b0;
    $display("test pullups done");
    wr(`OFS_ANALOG_SELECT, 8'h00);
    wr(`OFS_PIN_DIRECTION, 8'h3f);
    ext_val <= 6'h00;
    wr(`OFS_CHANGE_IRQ_ENABLE, 8'h02);
    rd(`OFS_PIN_DATA, 8'h00);
    ext_val <= 6'h02;
    repeat (4) @(posedge clk);
    rd(`OFS_CONTROL, 8'h01);
    chk({31'h0, wake}, 32'h0000_0001);
    wr(`OFS_CONTROL, 8'h02);
    repeat (3) @(posedge clk);
    rd(`OFS_CONTROL, 8'h03);
    chk({31'h0, irq}, 32'h0000_0001);
    chk({16'h0, irq_vector}, 32'h0000_0004);
    rd(`OFS_PIN_DATA, 8'h02);
    wr(`OFS_CONTROL, 8'h02);
    repeat (3) @(posedge clk);
    rd(`OFS_CONTROL, 8'h02);
    chk({31'h0, irq}, 32'h0000_0000);
    // a plain reset keeps the last-read latch, so no false mismatch
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wr(`OFS_ANALOG_SELECT, 8'h00);
    repeat (4) @(posedge clk);
    rd(`OFS_CONTROL, 8'h04);
    rd(`OFS_CHANGE_IRQ_ENABLE, 8'h02);
    wr(`OFS_ANALOG_SELECT, 8'h02);
    ext_val <= 6'h00;
    repeat (4) @(posedge clk);
    rd(`OFS_CONTROL, 8'h04);
    $display("test change_flag done");
    // charge the capacitor, arm the change, release, sink, sleep
    wr(`OFS_ANALOG_SELECT, 8'h00);
    wr(`OFS_PIN_DATA, 8'h01);
    wr(`OFS_PIN_DIRECTION, 8'h3e);
    ext_en <= 6'h3e;
    wr(`OFS_CHANGE_IRQ_ENABLE, 8'h01);
    wr(`OFS_PIN_DIRECTION, 8'h3f);
    rd(`OFS_PIN_DATA, 8'h01);
    wr(`OFS_CONTROL, 8'h0c);
    repeat (2) @(posedge clk);
    chk({31'h0, pin0_sink_en}, 32'h0000_0001);
    repeat (25) @(posedge clk);
    chk({31'h0, wake}, 32'h0000_0001);
    $display("test low_power_wake done");
    end_sim();
  end
endmodule : six_bit_port_with_change_wake_bench
